// File: pirq_map.vh
// Purpose: shared constants of the PCIe interrupt request block
// Assumes: included by its bare name by every design file of the block
// Notes:   register offsets are byte addresses on a 32-bit AXI4-Lite bus
`ifndef PIRQ_MAP_VH
`define PIRQ_MAP_VH

// ==========
// register offsets
`define PIRQ_REG_ID         12'h000
`define PIRQ_REG_STATUS     12'h004
`define PIRQ_REG_MASK       12'h008
`define PIRQ_REG_MODE       12'h00C
`define PIRQ_REG_PENDING    12'h010
`define PIRQ_REG_PBA        12'h014
`define PIRQ_REG_LEGMAP0    12'h040
`define PIRQ_REG_LEGMAP1    12'h044
`define PIRQ_REG_VECMAP0    12'h080
`define PIRQ_REG_VECMAP_END 12'h09C
`define PIRQ_REG_MSIX_BASE  12'h100

// ==========
// reset values and identity
`define PIRQ_ID_VALUE       32'h00C0FFEE
`define PIRQ_MASK_RST       4'h0
`define PIRQ_MAP_RST        32'h00000000
`define PIRQ_MSIX_CTRL_RST  32'h00000001

// ==========
// status event bit positions
`define PIRQ_EV_MSG_SENT    0
`define PIRQ_EV_DEASSERT    1
`define PIRQ_EV_NO_TYPE     2
`define PIRQ_EV_MSIX_MASKED 3
`define PIRQ_EV_W           4

// ==========
// active interrupt type codes
`define PIRQ_MODE_NONE      2'h0
`define PIRQ_MODE_LEGACY    2'h1
`define PIRQ_MODE_MSI       2'h2
`define PIRQ_MODE_MSIX      2'h3

// ==========
// field widths and bus answers
`define PIRQ_SRC_IW         5
`define PIRQ_VEC_W          5
`define PIRQ_RESP_OKAY      2'h0
`define PIRQ_RESP_SLVERR    2'h2

`endif

// File: pirq_chan.v
// Purpose: request and acknowledge handshake of one interrupt source
// Assumes: req is held by the source until serviced; done is a one-cycle pulse
// Notes:   legacy sources need a second message before they return to idle
`default_nettype none
`include "pirq_map.vh"

module pirq_chan (
	input  wire clk_sys,
	input  wire sys_rst,
	input  wire req,
	input  wire legacy,
	input  wire done,
	output wire need_msg,
	output wire need_deassert,
	output wire pending,
	output wire holds_line,
	output reg  ack_q
);

	// ==========
	// state machine
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ASK  = 2'h1;
	localparam [1:0] S_HOLD = 2'h2;
	localparam [1:0] S_DROP = 2'h3;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg       legacy_q;

	assign need_msg      = (state_q == S_ASK) || (state_q == S_DROP);
	assign need_deassert = (state_q == S_DROP);
	assign pending       = (state_q == S_ASK) || (state_q == S_HOLD);
	assign holds_line    = (state_q == S_HOLD) && legacy_q;

	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (req)
					state_d = S_ASK;
			end
			S_ASK: begin
				if (done)
					state_d = S_HOLD;
			end
			S_HOLD: begin
				if (!req)
					state_d = legacy_q ? S_DROP : S_IDLE;
			end
			S_DROP: begin
				if (done)
					state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q  <= S_IDLE;
			legacy_q <= 1'b0;
			ack_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			ack_q   <= done && need_msg;
			if (state_q == S_ASK && done)
				legacy_q <= legacy;
		end
	end

endmodule
`default_nettype wire

// File: pirq_top.v
// Purpose: collects user and DMA channel interrupt wires and raises INTx, MSI or MSI-X
// Assumes: one clock; host type enables come from the PCIe block's config space
// Notes:   sources are served one message at a time, lowest index first
//
// Behaviour
// - user request bits plus one wire per DMA channel become host interrupts.
// - each interrupt type exists only if built in; the host enables any subset.
// - only one type is active, MSI-X before MSI before legacy.
// - with legacy active, any asserted request raises a legacy interrupt.
// - every request bit has its own independent request and acknowledge.
// - acknowledge is given after the message is handed to the PCIe block, or at once when a shared legacy line needs no message.
// - the pending indication stays set while the request is held.
// - the second legacy acknowledge follows the sent deassert message, or its skip while another source holds the line.
// - map registers route each source to INTA, INTB, INTC or INTD.
// - with MSI or MSI-X active the matching message is sent, MSI-X winning.
// - map registers give each source a vector; MSI-X has a table and pending array.
`default_nettype none
`include "pirq_map.vh"

module pirq_top #(
	parameter USR_N        = 16,
	parameter CH_N         = 8,
	parameter SUPPORT_MSIX = 1,
	parameter SUPPORT_MSI  = 1,
	parameter SUPPORT_LEG  = 1,
	parameter MSIX_IW      = 3
) (
	input  wire                    clk_sys,
	input  wire                    sys_rst,
	input  wire [USR_N-1:0]        core0_user_interrupt_request,
	output wire [USR_N-1:0]        user_interrupt_ack,
	input  wire [CH_N-1:0]         dma_channel_interrupt,
	input  wire                    host_msix_enable,
	input  wire                    host_msi_enable,
	input  wire                    host_legacy_enable,
	output reg                     legacy_msg_valid_q,
	output reg                     legacy_msg_assert_q,
	output reg  [1:0]              legacy_msg_line_q,
	input  wire                    legacy_msg_done,
	output reg                     msi_msg_valid_q,
	output reg  [`PIRQ_VEC_W-1:0]  msi_msg_vector_q,
	input  wire                    msi_msg_done,
	output reg                     msix_msg_valid_q,
	output reg  [63:0]             msix_msg_addr_q,
	output reg  [31:0]             msix_msg_data_q,
	input  wire                    msix_msg_done,
	output wire                    irq_out,
	input  wire [11:0]             s_axi_awaddr,
	input  wire                    s_axi_awvalid,
	output wire                    s_axi_awready,
	input  wire [31:0]             s_axi_wdata,
	input  wire [3:0]              s_axi_wstrb,
	input  wire                    s_axi_wvalid,
	output wire                    s_axi_wready,
	output reg  [1:0]              s_axi_bresp,
	output reg                     s_axi_bvalid,
	input  wire                    s_axi_bready,
	input  wire [11:0]             s_axi_araddr,
	input  wire                    s_axi_arvalid,
	output wire                    s_axi_arready,
	output reg  [31:0]             s_axi_rdata,
	output reg  [1:0]              s_axi_rresp,
	output reg                     s_axi_rvalid,
	input  wire                    s_axi_rready
);

	localparam NS       = USR_N + CH_N;
	localparam MSIX_VEC = 1 << MSIX_IW;

	// ==========
	// active type selection
	reg [1:0] mode;

	always @* begin
		if (SUPPORT_MSIX != 0 && host_msix_enable)
			mode = `PIRQ_MODE_MSIX;
		else if (SUPPORT_MSI != 0 && host_msi_enable)
			mode = `PIRQ_MODE_MSI;
		else if (SUPPORT_LEG != 0 && host_legacy_enable)
			mode = `PIRQ_MODE_LEGACY;
		else
			mode = `PIRQ_MODE_NONE;
	end

	// ==========
	// configuration storage
	reg [63:0]               leg_map_q;
	reg [255:0]              vec_map_q;
	reg [31:0]               mx_alo_q [0:MSIX_VEC-1];
	reg [31:0]               mx_ahi_q [0:MSIX_VEC-1];
	reg [31:0]               mx_data_q [0:MSIX_VEC-1];
	reg [31:0]               mx_ctrl_q [0:MSIX_VEC-1];
	reg [MSIX_VEC-1:0]       pba_q;
	reg [`PIRQ_EV_W-1:0]     status_q;
	reg [`PIRQ_EV_W-1:0]     mask_q;
	reg [3:0]                line_on_q;

	// ==========
	// per-source handshakes
	wire [NS-1:0] src_req;
	wire [NS-1:0] need_msg;
	wire [NS-1:0] need_deassert;
	wire [NS-1:0] pending;
	wire [NS-1:0] holds_line;
	wire [NS-1:0] ack;
	reg  [NS-1:0] done_vec;

	assign src_req            = {dma_channel_interrupt, core0_user_interrupt_request};
	assign user_interrupt_ack = ack[USR_N-1:0];

	genvar g;
	generate
		for (g = 0; g < NS; g = g + 1) begin : g_src
			pirq_chan u_chan (
				.clk_sys       (clk_sys),
				.sys_rst       (sys_rst),
				.req           (src_req[g]),
				.legacy        (mode == `PIRQ_MODE_LEGACY),
				.done          (done_vec[g]),
				.need_msg      (need_msg[g]),
				.need_deassert (need_deassert[g]),
				.pending       (pending[g]),
				.holds_line    (holds_line[g]),
				.ack_q         (ack[g])
			);
		end
	endgenerate

	// ==========
	// selection of the next message
	reg [3:0]                line_hold;
	reg                      sel_valid;
	reg [`PIRQ_SRC_IW-1:0]   sel;
	reg                      sel_skip;
	reg [1:0]                sel_line;
	reg [`PIRQ_VEC_W-1:0]    sel_vec;
	reg [`PIRQ_EV_W-1:0]     ev;
	reg [MSIX_VEC-1:0]       pba_set;
	reg                      elig;
	integer                  i;

	always @* begin
		line_hold = 4'h0;
		sel_valid = 1'b0;
		sel       = {`PIRQ_SRC_IW{1'b0}};
		pba_set   = {MSIX_VEC{1'b0}};
		ev        = {`PIRQ_EV_W{1'b0}};
		elig      = 1'b0;
		for (i = 0; i < NS; i = i + 1) begin
			if (holds_line[i])
				line_hold[leg_map_q[2*i+:2]] = 1'b1;
		end
		for (i = NS - 1; i >= 0; i = i - 1) begin
			if (need_deassert[i])
				elig = 1'b1;
			else if (mode == `PIRQ_MODE_MSIX)
				elig = !mx_ctrl_q[vec_map_q[8*i+:MSIX_IW]][0];
			else
				elig = (mode != `PIRQ_MODE_NONE);
			if (need_msg[i] && !need_deassert[i] && mode == `PIRQ_MODE_NONE)
				ev[`PIRQ_EV_NO_TYPE] = 1'b1;
			// masked vector parks in pending array
			if (need_msg[i] && !need_deassert[i] && mode == `PIRQ_MODE_MSIX && !elig) begin
				pba_set[vec_map_q[8*i+:MSIX_IW]] = 1'b1;
				ev[`PIRQ_EV_MSIX_MASKED]          = 1'b1;
			end
			if (need_msg[i] && elig) begin
				sel_valid = 1'b1;
				sel       = i[`PIRQ_SRC_IW-1:0];
			end
		end
		sel_line = leg_map_q[2*sel+:2];
		sel_vec  = vec_map_q[8*sel+:`PIRQ_VEC_W];
		// shared lines: only the first assert goes on the wire; a deassert is skipped while another source holds the line
		if (need_deassert[sel])
			sel_skip = line_hold[sel_line];
		else
			sel_skip = (mode == `PIRQ_MODE_LEGACY) && line_on_q[sel_line];
	end

	// ==========
	// message sequencer
	localparam A_IDLE = 1'b0;
	localparam A_WAIT = 1'b1;

	reg                    arb_q;
	reg [`PIRQ_SRC_IW-1:0] cur_q;
	reg                    cur_deassert_q;
	reg [1:0]              cur_line_q;
	reg [MSIX_IW-1:0]      cur_mx_q;
	wire                   msg_done;

	assign msg_done = legacy_msg_done || msi_msg_done || msix_msg_done;

	always @* begin
		done_vec = {NS{1'b0}};
		case (arb_q)
			A_IDLE: begin
				if (sel_valid && sel_skip)
					done_vec[sel] = 1'b1;
			end
			A_WAIT: begin
				if (msg_done)
					done_vec[cur_q] = 1'b1;
			end
			default: done_vec = {NS{1'b0}};
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			arb_q               <= A_IDLE;
			cur_q               <= {`PIRQ_SRC_IW{1'b0}};
			cur_deassert_q      <= 1'b0;
			cur_line_q          <= 2'h0;
			cur_mx_q            <= {MSIX_IW{1'b0}};
			line_on_q           <= 4'h0;
			legacy_msg_valid_q  <= 1'b0;
			legacy_msg_assert_q <= 1'b0;
			legacy_msg_line_q   <= 2'h0;
			msi_msg_valid_q     <= 1'b0;
			msi_msg_vector_q    <= {`PIRQ_VEC_W{1'b0}};
			msix_msg_valid_q    <= 1'b0;
			msix_msg_addr_q     <= 64'h0000000000000000;
			msix_msg_data_q     <= 32'h00000000;
		end else begin
			case (arb_q)
				A_IDLE: begin
					if (sel_valid && !sel_skip) begin
						arb_q          <= A_WAIT;
						cur_q          <= sel;
						cur_deassert_q <= need_deassert[sel];
						cur_line_q     <= sel_line;
						cur_mx_q       <= sel_vec[MSIX_IW-1:0];
						if (need_deassert[sel] || mode == `PIRQ_MODE_LEGACY) begin
							legacy_msg_valid_q  <= 1'b1;
							legacy_msg_assert_q <= !need_deassert[sel];
							legacy_msg_line_q   <= sel_line;
						end else if (mode == `PIRQ_MODE_MSIX) begin
							msix_msg_valid_q <= 1'b1;
							msix_msg_addr_q  <= {mx_ahi_q[sel_vec[MSIX_IW-1:0]],
								mx_alo_q[sel_vec[MSIX_IW-1:0]]};
							msix_msg_data_q  <= mx_data_q[sel_vec[MSIX_IW-1:0]];
						end else begin
							msi_msg_valid_q  <= 1'b1;
							msi_msg_vector_q <= sel_vec;
						end
					end
				end
				A_WAIT: begin
					if (msg_done) begin
						arb_q              <= A_IDLE;
						legacy_msg_valid_q <= 1'b0;
						msi_msg_valid_q    <= 1'b0;
						msix_msg_valid_q   <= 1'b0;
						if (legacy_msg_valid_q)
							line_on_q[cur_line_q] <= !cur_deassert_q;
					end
				end
				default: arb_q <= A_IDLE;
			endcase
		end
	end

	// ==========
	// AXI4-Lite slave
	reg         aw_hold_q;
	reg [11:0]  aw_addr_q;
	reg         w_hold_q;
	reg [31:0]  w_data_q;
	reg [3:0]   w_strb_q;
	wire        wr_fire;
	wire [11:0] ra;
	reg  [31:0] rd_d;
	reg         rd_err;
	reg         wr_err;
	wire        mx_wr;
	wire [MSIX_IW-1:0] mx_wi;
	wire        mx_rd;
	wire [MSIX_IW-1:0] mx_ri;

	assign s_axi_awready = !aw_hold_q;
	assign s_axi_wready  = !w_hold_q;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign ra            = s_axi_araddr;
	assign mx_wr         = aw_addr_q >= `PIRQ_REG_MSIX_BASE &&
		aw_addr_q < `PIRQ_REG_MSIX_BASE + 16 * MSIX_VEC;
	assign mx_wi         = aw_addr_q[MSIX_IW+3:4];
	assign mx_rd         = ra >= `PIRQ_REG_MSIX_BASE && ra < `PIRQ_REG_MSIX_BASE + 16 * MSIX_VEC;
	assign mx_ri         = ra[MSIX_IW+3:4];

	function [31:0] merge;
		input [31:0] old;
		input [31:0] val;
		input [3:0]  strb;
		integer      b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b])
					merge[8*b+:8] = val[8*b+:8];
			end
		end
	endfunction

	always @* begin
		rd_d   = 32'h00000000;
		rd_err = 1'b0;
		if (mx_rd) begin
			case (ra[3:2])
				2'h0:    rd_d = mx_alo_q[mx_ri];
				2'h1:    rd_d = mx_ahi_q[mx_ri];
				2'h2:    rd_d = mx_data_q[mx_ri];
				default: rd_d = mx_ctrl_q[mx_ri];
			endcase
		end else if (ra >= `PIRQ_REG_VECMAP0 && ra <= `PIRQ_REG_VECMAP_END) begin
			rd_d = vec_map_q[32*ra[4:2]+:32];
		end else begin
			case (ra)
				`PIRQ_REG_ID:      rd_d = `PIRQ_ID_VALUE;
				`PIRQ_REG_STATUS:  rd_d[`PIRQ_EV_W-1:0] = status_q;
				`PIRQ_REG_MASK:    rd_d[`PIRQ_EV_W-1:0] = mask_q;
				`PIRQ_REG_MODE:    rd_d[8:0] = {SUPPORT_LEG != 0, SUPPORT_MSI != 0,
					SUPPORT_MSIX != 0, host_legacy_enable, host_msi_enable,
					host_msix_enable, arb_q, mode};
				`PIRQ_REG_PENDING: rd_d[NS-1:0] = pending;
				`PIRQ_REG_PBA:     rd_d[MSIX_VEC-1:0] = pba_q;
				`PIRQ_REG_LEGMAP0: rd_d = leg_map_q[31:0];
				`PIRQ_REG_LEGMAP1: rd_d = leg_map_q[63:32];
				default:           rd_err = 1'b1;
			endcase
		end
	end

	always @* begin
		wr_err = 1'b0;
		if (!mx_wr && !(aw_addr_q >= `PIRQ_REG_VECMAP0 && aw_addr_q <= `PIRQ_REG_VECMAP_END))
			case (aw_addr_q)
				`PIRQ_REG_STATUS, `PIRQ_REG_MASK, `PIRQ_REG_LEGMAP0, `PIRQ_REG_LEGMAP1,
				`PIRQ_REG_ID, `PIRQ_REG_MODE, `PIRQ_REG_PENDING, `PIRQ_REG_PBA:
					wr_err = 1'b0;
				default: wr_err = 1'b1;
			endcase
	end

	// ==========
	// register writes, status and pending array
	wire [`PIRQ_EV_W-1:0] ev_seen;
	wire [MSIX_VEC-1:0]   pba_clr;
	integer               v;

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			aw_hold_q    <= 1'b0;
			aw_addr_q    <= 12'h000;
			w_hold_q     <= 1'b0;
			w_data_q     <= 32'h00000000;
			w_strb_q     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PIRQ_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `PIRQ_RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
			leg_map_q    <= {`PIRQ_MAP_RST, `PIRQ_MAP_RST};
			vec_map_q    <= {8{`PIRQ_MAP_RST}};
			status_q     <= {`PIRQ_EV_W{1'b0}};
			mask_q       <= `PIRQ_MASK_RST;
			pba_q        <= {MSIX_VEC{1'b0}};
			for (v = 0; v < MSIX_VEC; v = v + 1) begin
				mx_alo_q[v]  <= 32'h00000000;
				mx_ahi_q[v]  <= 32'h00000000;
				mx_data_q[v] <= 32'h00000000;
				mx_ctrl_q[v] <= `PIRQ_MSIX_CTRL_RST;
			end
		end else begin
			if (s_axi_awvalid && !aw_hold_q) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_hold_q) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_fire) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
			end
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_d;
				s_axi_rresp  <= rd_err ? `PIRQ_RESP_SLVERR : `PIRQ_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end

			// events set sticky bits; a set in the clear cycle wins
			status_q <= (status_q & ~((wr_fire && aw_addr_q == `PIRQ_REG_STATUS) ?
				w_data_q[`PIRQ_EV_W-1:0] : {`PIRQ_EV_W{1'b0}})) | ev_seen;
			pba_q    <= (pba_q & ~pba_clr) | pba_set;

			if (wr_fire && !wr_err) begin
				if (mx_wr) begin
					case (aw_addr_q[3:2])
						2'h0:    mx_alo_q[mx_wi]  <= merge(mx_alo_q[mx_wi], w_data_q, w_strb_q);
						2'h1:    mx_ahi_q[mx_wi]  <= merge(mx_ahi_q[mx_wi], w_data_q, w_strb_q);
						2'h2:    mx_data_q[mx_wi] <= merge(mx_data_q[mx_wi], w_data_q, w_strb_q);
						default: mx_ctrl_q[mx_wi] <= merge(mx_ctrl_q[mx_wi], w_data_q, w_strb_q);
					endcase
				end else if (aw_addr_q >= `PIRQ_REG_VECMAP0) begin
					vec_map_q[32*aw_addr_q[4:2]+:32] <= merge(vec_map_q[32*aw_addr_q[4:2]+:32],
						w_data_q, w_strb_q) & 32'h1F1F1F1F;
				end else if (aw_addr_q == `PIRQ_REG_MASK) begin
					if (w_strb_q[0])
						mask_q <= w_data_q[`PIRQ_EV_W-1:0];
				end else if (aw_addr_q == `PIRQ_REG_LEGMAP0) begin
					leg_map_q[31:0] <= merge(leg_map_q[31:0], w_data_q, w_strb_q);
				end else if (aw_addr_q == `PIRQ_REG_LEGMAP1) begin
					leg_map_q[63:32] <= merge(leg_map_q[63:32], w_data_q, w_strb_q);
				end
			end
		end
	end

	// ==========
	// event collection and interrupt output
	assign ev_seen = {ev[`PIRQ_EV_MSIX_MASKED], ev[`PIRQ_EV_NO_TYPE],
		arb_q == A_WAIT && msg_done && cur_deassert_q,
		arb_q == A_WAIT && msg_done};
	// pending bit clears when its vector is sent
	assign pba_clr = (arb_q == A_WAIT && msix_msg_valid_q && msg_done) ?
		({{(MSIX_VEC-1){1'b0}}, 1'b1} << cur_mx_q) : {MSIX_VEC{1'b0}};
	assign irq_out = |(status_q & mask_q);

endmodule
`default_nettype wire

// File: pirq_props.sv
// Purpose: concurrent checks on the interrupt request block's ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to pirq_top from the testbench top file
`default_nettype none
`include "pirq_map.vh"

module pirq_chk #(
	parameter USR_N = 16
) (
	input wire logic                   clk_sys,
	input wire logic                   sys_rst,
	input wire logic [USR_N-1:0]       user_interrupt_ack,
	input wire logic                   host_msix_enable,
	input wire logic                   host_msi_enable,
	input wire logic                   host_legacy_enable,
	input wire logic                   legacy_msg_valid_q,
	input wire logic                   legacy_msg_assert_q,
	input wire logic [1:0]             legacy_msg_line_q,
	input wire logic                   legacy_msg_done,
	input wire logic                   msi_msg_valid_q,
	input wire logic [`PIRQ_VEC_W-1:0] msi_msg_vector_q,
	input wire logic                   msi_msg_done,
	input wire logic                   msix_msg_valid_q,
	input wire logic                   msix_msg_done,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_ack_pulse;
		|user_interrupt_ack |=> (user_interrupt_ack & $past(user_interrupt_ack)) == '0;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_one_type;
		$onehot0({legacy_msg_valid_q, msi_msg_valid_q, msix_msg_valid_q});
	endproperty
	a_one_type: assert property (p_one_type) else $error("two message types at once");
	property p_msix_first;
		$rose(msi_msg_valid_q) |-> !host_msix_enable;
	endproperty
	a_msix_first: assert property (p_msix_first) else $error("msi sent with msix on");
	property p_msi_first;
		$rose(legacy_msg_valid_q) |-> !host_msix_enable && !host_msi_enable;
	endproperty
	a_msi_first: assert property (p_msi_first) else $error("legacy sent over msi");
	property p_msi_hold;
		msi_msg_valid_q && !msi_msg_done |=> msi_msg_valid_q && $stable(msi_msg_vector_q);
	endproperty
	a_msi_hold: assert property (p_msi_hold) else $error("msi request not held");
	property p_leg_hold;
		legacy_msg_valid_q && !legacy_msg_done |=> legacy_msg_valid_q
			&& $stable({legacy_msg_assert_q, legacy_msg_line_q});
	endproperty
	a_leg_hold: assert property (p_leg_hold) else $error("legacy request not held");
	property p_msi_end;
		msi_msg_valid_q && msi_msg_done |=> !msi_msg_valid_q;
	endproperty
	a_msi_end: assert property (p_msi_end) else $error("msi request after done");
	property p_ack_after;
		|user_interrupt_ack && (host_msi_enable || host_msix_enable)
			|-> $past(msi_msg_done || msix_msg_done);
	endproperty
	a_ack_after: assert property (p_ack_after) else $error("ack before hand-over");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
endmodule
`default_nettype wire

// File: pirq_user.sv
// Purpose: user logic that raises, holds and drops interrupt requests
// Assumes: raise and serviced are one-cycle pulses from the testbench
// Notes:   a raise while a bit is busy is ignored, as real user logic would
`default_nettype none

module pirq_user #(
	parameter N = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic         legacy,
	input  wire logic [N-1:0] raise,
	input  wire logic [N-1:0] serviced,
	input  wire logic [N-1:0] ack,
	output var  logic [N-1:0] req_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// per-bit handshake
	logic [1:0] st_q [N];
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < N; i++) begin
			if (sys_rst) begin
				st_q[i] <= 2'h0;
				req_q[i] <= 1'b0;
			end else case (st_q[i])
				2'h0: if (raise[i]) begin
					req_q[i] <= 1'b1;
					st_q[i] <= 2'h1;
				end
				2'h1: if (ack[i]) st_q[i] <= 2'h2;
				2'h2: if (serviced[i]) begin
					req_q[i] <= 1'b0;
					st_q[i] <= legacy ? 2'h3 : 2'h0;
				end
				default: if (ack[i]) st_q[i] <= 2'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench of the interrupt request block
// Assumes: message done pulses come from the bench after a random delay
// Notes:   expected results queue up; one monitor compares them
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, sys_rst, host_msix_enable, host_msi_enable, host_legacy_enable;
	logic [15:0] core0_user_interrupt_request, user_interrupt_ack, raise, serviced;
	logic [7:0]  dma_channel_interrupt;
	logic        legacy_msg_valid_q, legacy_msg_assert_q, legacy_msg_done;
	logic [1:0]  legacy_msg_line_q, s_axi_bresp, s_axi_rresp;
	logic        msi_msg_valid_q, msi_msg_done, msix_msg_valid_q, msix_msg_done, irq_out;
	logic [4:0]  msi_msg_vector_q;
	logic [63:0] msix_msg_addr_q;
	logic [31:0] msix_msg_data_q, s_axi_wdata, s_axi_rdata, d;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [33:0] e, q_msg[$], q_rsp[$];
	logic [4:0]  q_ack[$];
	int          fails, checks_done, seed = 8, dly;

	pirq_top #(.USR_N(16), .CH_N(8)) pirq_top_inst (.*);
	pirq_user #(.N(16)) pirq_user_inst (.clk_sys, .sys_rst, .raise, .serviced,
		.legacy(host_legacy_enable && !host_msi_enable && !host_msix_enable),
		.ack(user_interrupt_ack), .req_q(core0_user_interrupt_request));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ==========
	// pcie block: takes each message after a random delay
	always @(posedge clk_sys) begin
		if (msi_msg_done || msix_msg_done || legacy_msg_done
			|| !(msi_msg_valid_q || msix_msg_valid_q || legacy_msg_valid_q)) begin
			{msix_msg_done, msi_msg_done, legacy_msg_done} <= 3'h0;
		end else if (dly != 0) dly <= dly - 1;
		else begin
			{msix_msg_done, msi_msg_done, legacy_msg_done} <=
				{msix_msg_valid_q, msi_msg_valid_q, legacy_msg_valid_q};
			dly <= $random(seed) & 3;
		end
	end
	// ==========
	// monitor
	always @(posedge clk_sys) if (!sys_rst) begin
		for (int i = 0; i < 16; i++) if (user_interrupt_ack[i] !== 1'b0) begin
			e = {29'h0, q_ack.pop_front()};
			`CHK(i[4:0], e[4:0])
		end
		if (msi_msg_valid_q && msi_msg_done) begin
			e = q_msg.pop_front();
			`CHK({2'h2, 27'h0, msi_msg_vector_q}, e)
		end
		if (msix_msg_valid_q && msix_msg_done) begin
			e = q_msg.pop_front();
			`CHK({2'h3, msix_msg_data_q} ^ msix_msg_addr_q, e)
		end
		if (legacy_msg_valid_q && legacy_msg_done) begin
			e = q_msg.pop_front();
			`CHK({2'h1, 29'h0, legacy_msg_assert_q, legacy_msg_line_q}, e)
		end
		if (s_axi_rvalid && s_axi_rready) begin
			e = q_rsp.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, e)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			e = q_rsp.pop_front();
			`CHK({s_axi_bresp, 32'h0}, e)
		end
	end
	// ==========
	// tasks
	task test_done;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task tmo;
		fails++;
		test_done();
	endtask
	task axw(logic [11:0] a, logic [31:0] v, logic [1:0] r);
		q_rsp.push_back({r, 32'h0});
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && s_axi_bvalid !== 1'b1; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		if (s_axi_bvalid !== 1'b1) tmo();
		s_axi_bready <= 1'b0;
	endtask
	task axr(logic [11:0] a, logic [33:0] x);
		q_rsp.push_back(x);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && s_axi_rvalid !== 1'b1; n++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		if (s_axi_rvalid !== 1'b1) tmo();
		s_axi_rready <= 1'b0;
	endtask
	task up(logic [15:0] r, logic [15:0] s);
		raise <= r;
		serviced <= s;
		@(posedge clk_sys);
		raise <= 16'h0;
		serviced <= 16'h0;
	endtask
	task wq;
		for (int n = 0; n < 200; n++) begin
			@(posedge clk_sys);
			if (q_ack.size() == 0 && q_msg.size() == 0) return;
		end
		tmo();
	endtask
	// ==========
	// main sequence
	initial begin
		{sys_rst, host_msix_enable, host_msi_enable, host_legacy_enable} = 4'h8;
		{raise, serviced, dma_channel_interrupt, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		axr(12'h008, 34'h0);
		axr(12'h00C, 34'h1C0);
		axr(12'h0FC, 34'h200000000);
		axw(12'h0FC, 32'h1, 2'h2);
		axw(12'h080, 32'h0A000005, 2'h0);
		s_axi_wstrb <= 4'h2;
		axw(12'h090, 32'hFFFF1FFF, 2'h0);
		s_axi_wstrb <= 4'hF;
		axw(12'h008, 32'h1, 2'h0);
		// msi wins over legacy; two user bits and one channel together
		host_msi_enable <= 1'b1;
		host_legacy_enable <= 1'b1;
		dma_channel_interrupt <= 8'h02;
		q_msg = '{34'h20000001F, 34'h200000005, 34'h20000000A};
		q_ack = '{5'd0, 5'd3};
		up(16'h0009, 16'h0);
		wq();
		repeat (20) @(posedge clk_sys);
		axr(12'h010, 34'h00020009);
		`CHK(irq_out, 1'b1)
		axw(12'h004, 32'h1, 2'h0);
		`CHK(irq_out, 1'b0)
		dma_channel_interrupt <= 8'h00;
		up(16'h0, 16'h0009);
		repeat (4) @(posedge clk_sys);
		axr(12'h010, 34'h0);
		// msix wins; masked vector waits in the pending array
		// switch while idle
		host_msix_enable <= 1'b1;
		d = $random(seed);
		axw(12'h108, d, 2'h0);
		up(16'h0020, 16'h0);
		repeat (10) @(posedge clk_sys);
		axr(12'h014, 34'h1);
		axr(12'h004, 34'h8);
		q_msg.push_back({2'h3, d});
		q_ack.push_back(5'd5);
		axw(12'h10C, 32'h0, 2'h0);
		wq();
		up(16'h0, 16'h0020);
		// legacy: bits 2 and 6 share the third line
		host_msix_enable <= 1'b0;
		host_msi_enable <= 1'b0;
		axw(12'h040, 32'h00002020, 2'h0);
		q_msg.push_back(34'h100000006);
		q_ack = '{5'd2, 5'd6};
		up(16'h0044, 16'h0);
		wq();
		q_ack.push_back(5'd2);
		up(16'h0, 16'h0004);
		wq();
		q_msg.push_back(34'h100000002);
		q_ack.push_back(5'd6);
		up(16'h0, 16'h0040);
		wq();
		repeat (10) @(posedge clk_sys);
		axr(12'h00C, 34'h1E1);
		axr(12'h004, 34'hB);
		test_done();
	end
endmodule

bind pirq_top pirq_chk #(.USR_N(USR_N)) pirq_chk_inst (.*);
`default_nettype wire
